/* actis_regs.vh */
// Register map, fields and codes for actis
// Notes on behaviour
// - Ch2 internal codes: bandgap, amp, alt, ground
// - Ch2 external codes 0-10 pins, rest float
// - Ch2 select only in two-channel mode
// - Auto interval is code plus one periods
// - Timer counts preload to ffff, overflows
// - Software may clear run bit, never set
// - Source 01: comparator edge starts, overflow stops
// - Source 10: enable rise starts, fall stops
// - Preload loads when stopped, else on overflow
// - Edge start needs enable and converter idle
// - Prescale select: high clock over 4 or 8
// - Low write buffered; high write commits both
// - High read latches low byte into buffer
// - Reference 01 internal supply, else external pin
// - Input class picks external or internal signal
// - Internal signal selected disconnects external channel
// - Two-channel mode: per-channel source and selector
// - Analog pin drops other functions and pull-up
// - Conversion clock is system clock over 2^code
// - Trigger source: pwm, cmp timer, enable timer, soft
`ifndef ACTIS_REGS_VH
`define ACTIS_REGS_VH
// ----------
// Register byte addresses
// ----------
`define ACTIS_OFF_INTERVAL  12'h000
`define ACTIS_OFF_TCTRL     12'h004
`define ACTIS_OFF_PRE_HIGH  12'h008
`define ACTIS_OFF_PRE_LOW   12'h00c
`define ACTIS_OFF_ADCCFG    12'h010
`define ACTIS_OFF_AUTOCFG   12'h014
`define ACTIS_OFF_CH1CFG    12'h018
`define ACTIS_OFF_CH2CFG    12'h01c
`define ACTIS_OFF_STATUS    12'h020
`define ACTIS_OFF_PINANA    12'h024
// ----------
// Field positions
// ----------
`define ACTIS_TC_RUN_BIT    4
`define ACTIS_TC_EDGE_BIT   1
`define ACTIS_TC_PSC_BIT    0
`define ACTIS_TWOCH_BIT     5
`define ACTIS_SRC_BIT       4
`define ACTIS_AUTOEN_BIT    8
// ----------
// Reset values and codes
// ----------
`define ACTIS_RST_BYTE      8'h00
`define ACTIS_RST_WORD      16'h0000
`define ACTIS_TMR_FULL      16'hffff
`define ACTIS_TS_PWM        2'h0
`define ACTIS_TS_CMP        2'h1
`define ACTIS_TS_EN         2'h2
`define ACTIS_TS_SOFT       2'h3
`define ACTIS_REF_INT       2'h1
`define ACTIS_PSC4_CNT      3'h3
`define ACTIS_PSC8_CNT      3'h7
// Analog select codes driven to the mux
`define ACTIS_SEL_EXT       3'h0
`define ACTIS_SEL_BG        3'h1
`define ACTIS_SEL_AMP       3'h2
`define ACTIS_SEL_AMPALT    3'h3
`define ACTIS_SEL_GND       3'h4
`define ACTIS_SEL_FLOAT     3'h5
`define ACTIS_EXT_LAST      4'ha
`endif

/* actis_top.v */
// Converter trigger timer, interval and input selection control
//
// Implementation choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "actis_regs.vh"
module actis_top (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire [11:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [11:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire        high_clk_tick,
   input  wire        protection_comparator_out,
   input  wire        conversion_busy,
   input  wire        conv_sel_ch2,
   output reg         timer_overflow,
   output reg         timer_run_out,
   output reg  [15:0] timer_count,
   output reg         conv_clk_tick,
   output reg  [4:0]  auto_interval_cycles,
   output reg  [2:0]  analog_sel_kind,
   output reg  [3:0]  analog_ext_channel,
   output reg         ext_channel_connect,
   output reg         ext_ref_connect,
   output reg  [10:0] pin_analog_mode,
   output reg  [10:0] pin_pullup_off,
   output reg  [10:0] pin_dir_override
);
   // ----------
   // Register state
   // ----------
   reg  [3:0]  auto_interval_code;     // Interval code
   reg         timer_run;              // Run bit
   reg         edge_start_enable;      // Comparator start enable
   reg         timer_prescale_select;  // Divide by 4 or 8
   reg  [7:0]  preload_high;           // Preload high byte
   reg  [7:0]  preload_low;            // Preload low byte
   reg  [7:0]  low_buffer;             // Shared low byte buffer
   reg  [2:0]  input_class_select;     // Manual/one-ch class
   reg  [1:0]  reference_select;       // Reference source
   reg  [2:0]  conversion_clock_select;// Clock divider code
   reg  [3:0]  external_channel_select;// Manual channel
   reg  [1:0]  auto_trigger_source;    // Trigger source
   reg         auto_conversion_enable; // Auto enable
   reg         two_channel_mode;       // Two-channel enable
   reg         ch1_source_select;      // Ch1 external
   reg  [3:0]  ch1_signal_select;      // Ch1 selector
   reg         ch2_source_select;      // Ch2 external
   reg  [3:0]  ch2_signal_select;      // Ch2 selector
   reg  [10:0] pin_analog_cfg;         // Pins set analog
   reg         cmp_prev;               // Comparator history
   reg         en_prev;                // Enable history
   reg  [2:0]  psc_cnt;                // Prescaler
   reg  [6:0]  ck_div;                 // Conversion divider
   // ----------
   // AXI4-Lite write channel
   // ----------
   reg         aw_held;                // Address taken
   reg  [11:0] aw_addr;                // Held address
   reg         w_held;                 // Data taken
   reg  [31:0] w_data;                 // Held data
   reg  [3:0]  w_strb;                 // Held strobes
   wire        wr_do;                  // Write commits now
   wire [7:0]  wb;                     // Written byte
   // Each channel accepts once until the response is taken
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign wr_do = aw_held && w_held;
   assign wb    = w_data[7:0];
   // Capture address and data in either order
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held      <= 1'b0;
         aw_addr      <= 12'h000;
         w_held       <= 1'b0;
         w_data       <= 32'h00000000;
         w_strb       <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_do) begin
            // Both halves present: answer next cycle
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr > `ACTIS_OFF_PINANA ||
                             aw_addr[1:0] != 2'h0) ? 2'h2 : 2'h0;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   // ----------
   // AXI4-Lite read channel
   // ----------
   wire        rd_do;                  // Read taken this edge
   reg  [31:0] rd_mux;                 // Read data select
   reg         rd_bad;                 // Unmapped read
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_do = s_axi_arvalid && s_axi_arready;
   // Read data; upper bits always zero
   always @* begin
      rd_mux = 32'h00000000;
      rd_bad = 1'b0;
      case (s_axi_araddr)
         `ACTIS_OFF_INTERVAL: rd_mux[3:0] = auto_interval_code;
         `ACTIS_OFF_TCTRL: begin
            rd_mux[`ACTIS_TC_RUN_BIT]  = timer_run;
            rd_mux[`ACTIS_TC_EDGE_BIT] = edge_start_enable;
            rd_mux[`ACTIS_TC_PSC_BIT]  = timer_prescale_select;
         end
         `ACTIS_OFF_PRE_HIGH: rd_mux[7:0] = preload_high;
         `ACTIS_OFF_PRE_LOW:  rd_mux[7:0] = low_buffer;
         `ACTIS_OFF_ADCCFG: rd_mux[11:0] = {external_channel_select,
            input_class_select, reference_select,
            conversion_clock_select};
         `ACTIS_OFF_AUTOCFG: begin
            rd_mux[7:6] = auto_trigger_source;
            rd_mux[`ACTIS_AUTOEN_BIT] = auto_conversion_enable;
         end
         `ACTIS_OFF_CH1CFG: rd_mux[5:0] = {two_channel_mode,
            ch1_source_select, ch1_signal_select};
         `ACTIS_OFF_CH2CFG: rd_mux[4:0] = {ch2_source_select,
            ch2_signal_select};
         `ACTIS_OFF_STATUS: rd_mux[16:0] = {timer_count, conversion_busy};
         `ACTIS_OFF_PINANA: rd_mux[10:0] = pin_analog_cfg;
         default: rd_bad = 1'b1;
      endcase
   end
   // Read answer registered one cycle after the address
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= 2'h0;
      end else if (rd_do) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_mux;
         s_axi_rresp  <= rd_bad ? 2'h2 : 2'h0;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
   // ----------
   // Timer control: start, stop, preload and count
   // ----------
   wire        wr_b0;                  // Byte lane 0 written
   wire        tick;                   // Prescaled timer tick
   wire        cmp_rise;               // Comparator rising edge
   wire        en_rise;                // Auto enable rising
   wire        en_fall;                // Auto enable falling
   wire        cmp_start;              // Comparator start allowed
   wire        at_full;                // Counter at full count
   assign wr_b0    = wr_do && w_strb[0];
   assign cmp_rise = protection_comparator_out && !cmp_prev;
   assign en_rise  = auto_conversion_enable && !en_prev;
   assign en_fall  = !auto_conversion_enable && en_prev;
   // Edge start gated by enable and idle converter
   assign cmp_start = cmp_rise && edge_start_enable &&
                      !conversion_busy;
   // Prescaler ends at count 3 or 7, on every 4th or 8th tick of high clock
   assign tick = high_clk_tick && (psc_cnt == (timer_prescale_select ?
                 `ACTIS_PSC8_CNT : `ACTIS_PSC4_CNT));
   assign at_full = (timer_count == `ACTIS_TMR_FULL);
   // Prescaler counts high-speed clock ticks
   always @(posedge aclk) begin
      if (!aresetn) begin
         psc_cnt <= 3'h0;
      end else if (!timer_run || tick) begin
         psc_cnt <= 3'h0;
      end else if (high_clk_tick) begin
         psc_cnt <= psc_cnt + 3'h1;
      end
   end
   // Run bit and counter; a start in the same cycle beats a stop
   always @(posedge aclk) begin
      if (!aresetn) begin
         timer_run      <= 1'b0;
         timer_count    <= `ACTIS_RST_WORD;
         timer_overflow <= 1'b0;
         cmp_prev       <= 1'b0;
         en_prev        <= 1'b0;
      end else begin
         cmp_prev       <= protection_comparator_out;
         en_prev        <= auto_conversion_enable;
         timer_overflow <= 1'b0;
         if (timer_run && tick) begin
            if (at_full) begin
               // Overflow: reload preload value
               timer_count    <= {preload_high, preload_low};
               timer_overflow <= 1'b1;
               if (auto_trigger_source == `ACTIS_TS_CMP)
                  timer_run <= 1'b0;
            end else begin
               timer_count <= timer_count + 16'h0001;
            end
         end else if (!timer_run) begin
            // Idle counter follows the preload value
            timer_count <= {preload_high, preload_low};
         end
         // Software write may only clear the run bit
         if (wr_b0 && aw_addr == `ACTIS_OFF_TCTRL &&
             !wb[`ACTIS_TC_RUN_BIT])
            timer_run <= 1'b0;
         if (auto_trigger_source == `ACTIS_TS_EN && en_fall)
            timer_run <= 1'b0;
         if (auto_trigger_source == `ACTIS_TS_CMP && cmp_start)
            timer_run <= 1'b1;
         if (auto_trigger_source == `ACTIS_TS_EN && en_rise)
            timer_run <= 1'b1;
      end
   end
   // ----------
   // Software configuration registers
   // ----------
   // Control writes during auto mode are the software's hazard
   always @(posedge aclk) begin
      if (!aresetn) begin
         auto_interval_code      <= 4'h0;
         edge_start_enable       <= 1'b0;
         timer_prescale_select   <= 1'b0;
         preload_high            <= `ACTIS_RST_BYTE;
         preload_low             <= `ACTIS_RST_BYTE;
         low_buffer              <= `ACTIS_RST_BYTE;
         input_class_select      <= 3'h0;
         reference_select        <= 2'h0;
         conversion_clock_select <= 3'h0;
         external_channel_select <= 4'h0;
         auto_trigger_source     <= `ACTIS_TS_PWM;
         auto_conversion_enable  <= 1'b0;
         two_channel_mode        <= 1'b0;
         ch1_source_select       <= 1'b0;
         ch1_signal_select       <= 4'h0;
         ch2_source_select       <= 1'b0;
         ch2_signal_select       <= 4'h0;
         pin_analog_cfg          <= 11'h000;
      end else begin
         // High byte read latches the low byte into the buffer
         if (rd_do && s_axi_araddr == `ACTIS_OFF_PRE_HIGH)
            low_buffer <= preload_low;
         if (wr_b0) begin
            case (aw_addr)
               `ACTIS_OFF_INTERVAL: auto_interval_code <= wb[3:0];
               `ACTIS_OFF_TCTRL: begin
                  edge_start_enable     <= wb[`ACTIS_TC_EDGE_BIT];
                  timer_prescale_select <= wb[`ACTIS_TC_PSC_BIT];
               end
               `ACTIS_OFF_PRE_HIGH: begin
                  preload_high <= wb;
                  preload_low  <= low_buffer;
               end
               `ACTIS_OFF_PRE_LOW: low_buffer <= wb;
               `ACTIS_OFF_ADCCFG: begin
                  conversion_clock_select <= wb[2:0];
                  reference_select        <= wb[4:3];
                  input_class_select      <= wb[7:5];
               end
               `ACTIS_OFF_AUTOCFG: auto_trigger_source <= wb[7:6];
               `ACTIS_OFF_CH1CFG: begin
                  two_channel_mode  <= wb[`ACTIS_TWOCH_BIT];
                  ch1_source_select <= wb[`ACTIS_SRC_BIT];
                  ch1_signal_select <= wb[3:0];
               end
               `ACTIS_OFF_CH2CFG: begin
                  ch2_source_select <= wb[`ACTIS_SRC_BIT];
                  ch2_signal_select <= wb[3:0];
               end
               `ACTIS_OFF_PINANA: pin_analog_cfg <= w_data[10:0];
               default: ;
            endcase
         end
         // Lane 1 holds channel select and auto enable
         if (wr_do && w_strb[1]) begin
            if (aw_addr == `ACTIS_OFF_ADCCFG)
               external_channel_select <= w_data[11:8];
            if (aw_addr == `ACTIS_OFF_AUTOCFG)
               auto_conversion_enable <= w_data[`ACTIS_AUTOEN_BIT];
         end
      end
   end
   // ----------
   // Conversion clock divider
   // ----------
   // Free-running divider; tick when the low code bits are all one
   always @(posedge aclk) begin
      if (!aresetn) begin
         ck_div        <= 7'h00;
         conv_clk_tick <= 1'b0;
      end else begin
         ck_div        <= ck_div + 7'h01;
         conv_clk_tick <= ((ck_div | ~((7'h01 << conversion_clock_select)
                          - 7'h01)) == 7'h7f);
      end
   end
   // ----------
   // Analog input and reference selection
   // ----------
   reg         use_ext;                // External source chosen
   reg  [3:0]  chan_sel;               // Selector in effect
   reg  [2:0]  next_kind;              // Resolved signal kind
   // Decode a 4-bit internal selector code
   function [2:0] int_kind;
      input [3:0] code;
      begin
         case (code)
            4'h1:    int_kind = `ACTIS_SEL_AMP;
            4'h2:    int_kind = `ACTIS_SEL_AMPALT;
            4'h3:    int_kind = `ACTIS_SEL_GND;
            default: int_kind = `ACTIS_SEL_BG;
         endcase
      end
   endfunction
   // Two-channel selectors act only in two-channel mode
   always @* begin
      if (two_channel_mode) begin
         use_ext  = conv_sel_ch2 ? ch2_source_select
                                 : ch1_source_select;
         chan_sel = conv_sel_ch2 ? ch2_signal_select
                                 : ch1_signal_select;
         next_kind = use_ext ? `ACTIS_SEL_EXT : int_kind(chan_sel);
      end else begin
         chan_sel = external_channel_select;
         case (input_class_select)
            3'h1:    next_kind = `ACTIS_SEL_BG;
            3'h2:    next_kind = `ACTIS_SEL_AMP;
            3'h3:    next_kind = `ACTIS_SEL_AMPALT;
            3'h4:    next_kind = `ACTIS_SEL_GND;
            default: next_kind = `ACTIS_SEL_EXT;
         endcase
         use_ext = (next_kind == `ACTIS_SEL_EXT);
      end
      // Codes past the last pin leave the input floating
      if (use_ext && chan_sel > `ACTIS_EXT_LAST)
         next_kind = `ACTIS_SEL_FLOAT;
   end
   // Registered mux controls; internal source opens external switch
   always @(posedge aclk) begin
      if (!aresetn) begin
         analog_sel_kind      <= `ACTIS_SEL_EXT;
         analog_ext_channel   <= 4'h0;
         ext_channel_connect  <= 1'b0;
         ext_ref_connect      <= 1'b1;
         auto_interval_cycles <= 5'h01;
         timer_run_out        <= 1'b0;
      end else begin
         analog_sel_kind     <= next_kind;
         analog_ext_channel  <= chan_sel;
         ext_channel_connect <= (next_kind == `ACTIS_SEL_EXT);
         ext_ref_connect     <= (reference_select !=
                                 `ACTIS_REF_INT);
         auto_interval_cycles <= {1'b0, auto_interval_code} +
                                 5'h01;
         timer_run_out       <= timer_run;
      end
   end
   // ----------
   // Pin function overrides, one per analog pin
   // ----------
   genvar gi;
   generate
      for (gi = 0; gi < 11; gi = gi + 1) begin : g_pin
         // Analog pin drops digital function, pull-up and direction
         always @(posedge aclk) begin
            if (!aresetn) begin
               pin_analog_mode[gi]  <= 1'b0;
               pin_pullup_off[gi]   <= 1'b0;
               pin_dir_override[gi] <= 1'b0;
            end else begin
               pin_analog_mode[gi]  <= pin_analog_cfg[gi];
               pin_pullup_off[gi]   <= pin_analog_cfg[gi];
               pin_dir_override[gi] <= pin_analog_cfg[gi];
            end
         end
      end
   endgenerate
endmodule // actis_top

/* actis_monitor.sv */
// Checker of actis_top port timing and selection relations
`timescale 1ns/1ps
module actis_monitor (
   input wire        aclk,
   input wire        aresetn,
   input wire        s_axi_awready,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   input wire        timer_overflow,
   input wire        timer_run_out,
   input wire [15:0] timer_count,
   input wire [4:0]  auto_interval_cycles,
   input wire [2:0]  analog_sel_kind,
   input wire        ext_channel_connect
);
   // ----------
   // Properties, one clock domain
   // ----------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   ext_off_a: assert property (
      analog_sel_kind != 3'h0 |-> !ext_channel_connect)
      else $error("external channel joined to internal signal");
   wrap_full_a: assert property (
      timer_overflow |-> $past(timer_count) == 16'hffff ||
      $past(timer_count, 2) == 16'hffff)
      else $error("overflow without full count");
   count_step_a: assert property (
      timer_run_out && $past(timer_run_out) && $changed(timer_count)
      |-> timer_count == $past(timer_count) + 16'h1 ||
      $past(timer_count) == 16'hffff)
      else $error("counter moved by more than one");
   ovf_gap_a: assert property (
      timer_overflow |=> !timer_overflow [*3])
      else $error("overflows closer than prescaled tick");
   ivl_range_a: assert property (
      auto_interval_cycles != 5'h0 && auto_interval_cycles <= 5'h10)
      else $error("interval outside one to sixteen");
   wr_done_a: assert property (
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response not retired");
   rd_done_a: assert property (
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read response not retired");
   aw_block_a: assert property (
      s_axi_bvalid |-> !s_axi_awready)
      else $error("write taken while response pending");
endmodule // actis_monitor
bind actis_top actis_monitor i_actis_monitor (.*);

/* actis_partner.sv */
// Far-side model: high-speed clock ticks and comparator output
`timescale 1ns/1ps
module actis_partner #(
   parameter DIV = 2 // Aclk cycles per high-speed period
) (
   input  wire aclk,
   input  wire aresetn,
   input  wire fire,
   output reg  high_clk_tick = 1'b0,
   output reg  protection_comparator_out = 1'b0
);
   reg [3:0] cnt  = 4'h0; // Tick divider
   reg [1:0] hold = 2'h0; // Comparator high time left
   // Free ticks; comparator high a few cycles per request
   always @(posedge aclk) begin
      cnt <= (!aresetn || cnt == DIV - 1) ? 4'h0 : cnt + 4'h1;
      high_clk_tick <= aresetn && cnt == DIV - 1;
      hold <= !aresetn ? 2'h0 : fire ? 2'h3 : hold - {1'b0, hold != 2'h0};
      protection_comparator_out <= fire || hold > 2'h1;
   end
endmodule // actis_partner

/* adc_trigger_timer_input_select_test.sv */
// Self-checking bench for the trigger timer and input selection
`timescale 1ns/1ps
`include "actis_regs.vh"
module adc_trigger_timer_input_select_test;
   localparam DIV = 2; // High-speed period in aclk cycles
   reg         aclk = 1'b0, aresetn = 1'b0, fire = 1'b0;
   reg  [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
   reg  [31:0] s_axi_wdata = 32'h0, seed = 32'd81, rd_d, v;
   reg         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   reg         s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   reg         s_axi_rready = 1'b0, conversion_busy = 1'b0;
   reg         conv_sel_ch2 = 1'b0;
   reg  [1:0]  rd_r;
   wire [3:0]  s_axi_wstrb = 4'hf;
   wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   wire        s_axi_rvalid, high_clk_tick, protection_comparator_out;
   wire        timer_overflow, timer_run_out, conv_clk_tick;
   wire        ext_channel_connect, ext_ref_connect;
   wire [1:0]  s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [15:0] timer_count;
   wire [4:0]  auto_interval_cycles;
   wire [2:0]  analog_sel_kind;
   wire [3:0]  analog_ext_channel;
   wire [10:0] pin_analog_mode, pin_pullup_off, pin_dir_override;
   integer     fail_count = 0, n_compared = 0, i, k, t;
   actis_top i_actis_top (.*);
   actis_partner #(.DIV(DIV)) i_actis_partner (.*);
   initial forever #12.5 aclk = ~aclk;
   // ----------
   // Model, bus tasks and compare
   // ----------
   function [31:0] xs(input [31:0] s); // Xorshift step
      reg [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      xs = x ^ (x << 5);
   endfunction
   function [2:0] mk(input [2:0] c, input [3:0] ch); // Class to kind
      mk = (c >= 3'h1 && c <= 3'h4) ? c : (ch > 4'ha) ? 3'h5 : 3'h0;
   endfunction
   function [2:0] m2(input src, input [3:0] s); // Channel-2 kind
      m2 = src ? mk(3'h0, s) : (s >= 4'h1 && s <= 4'h3) ? s[2:0] + 3'h1
         : 3'h1;
   endfunction
   task chk(input [31:0] seen, input [31:0] exp);
      n_compared = n_compared + 1;
      if (seen !== exp) begin
         fail_count = fail_count + 1;
         $display("unexpected %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task wr(input [11:0] a, input [31:0] d); // Address and data together
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      rd_r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task rd(input [11:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rd_d = s_axi_rdata;
      rd_r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task w3; // Outputs settle
      repeat (3) @(posedge aclk);
   endtask
   task gap(input s); // Cycles to next clock tick or overflow
      @(posedge aclk);
      t = 1;
      while ((s ? conv_clk_tick : timer_overflow) !== 1'b1) begin
         @(posedge aclk);
         t = t + 1;
      end
   endtask
   task pulse(input b); // Comparator edge, busy level b
      @(posedge aclk);
      conversion_busy <= b;
      fire <= 1'b1;
      @(posedge aclk);
      fire <= 1'b0;
      repeat (8) @(posedge aclk);
   endtask
   task wrap_up;
      $display("compared %0d mismatched %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // ----------
   // Scenarios
   // ----------
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`ACTIS_OFF_TCTRL);
      chk(rd_d, 32'h0);
      chk(auto_interval_cycles, 5'h1);
      for (i = 0; i < 4; i = i + 1) begin // Upper bits must read zero
         seed = xs(seed);
         wr(`ACTIS_OFF_INTERVAL, seed[7:0]);
         rd(`ACTIS_OFF_INTERVAL);
         chk(rd_d, seed[3:0]);
         w3;
         chk(auto_interval_cycles, seed[3:0] + 5'h1);
      end
      wr(`ACTIS_OFF_PINANA, seed[18:8]);
      w3;
      chk({pin_analog_mode, pin_pullup_off}, {2{seed[18:8]}});
      chk(pin_dir_override, seed[18:8]);
      wr(12'h040, 32'hffffffff);
      chk(rd_r, 2'h2);
      rd(12'h040);
      chk(rd_d, 32'h0);
      chk(rd_r, 2'h2);
      for (i = 0; i < 16; i = i + 1) begin // Manual mode selection
         seed = xs(seed);
         v = {20'h0, seed[11:8], i[2:0], seed[4:3], 3'h5};
         wr(`ACTIS_OFF_ADCCFG, v);
         w3;
         k = mk(i[2:0], seed[11:8]);
         chk(analog_sel_kind, k);
         chk(ext_channel_connect, k == 0);
         chk(ext_ref_connect, seed[4:3] != 2'h1);
         if (k == 0) chk(analog_ext_channel, seed[11:8]);
      end
      gap(1'b1);
      gap(1'b1);
      chk(t, 32);
      wr(`ACTIS_OFF_CH1CFG, 32'h20);
      conv_sel_ch2 <= 1'b1;
      for (i = 0; i < 32; i = i + 1) begin // Every channel-2 code
         wr(`ACTIS_OFF_CH2CFG, i);
         w3;
         chk(analog_sel_kind, m2(i[4], i[3:0]));
         if (i[4] && i < 27) chk(analog_ext_channel, i[3:0]);
      end
      wr(`ACTIS_OFF_CH1CFG, 32'h0);
      w3;
      chk(analog_sel_kind, mk(v[7:5], v[11:8]));
      wr(`ACTIS_OFF_PRE_LOW, 32'h34);
      wr(`ACTIS_OFF_PRE_HIGH, 32'hff);
      wr(`ACTIS_OFF_PRE_LOW, 32'h10);
      w3;
      chk(timer_count, 16'hff34);
      rd(`ACTIS_OFF_PRE_HIGH);
      chk(rd_d, 32'hff);
      rd(`ACTIS_OFF_PRE_LOW);
      chk(rd_d, 32'h34);
      wr(`ACTIS_OFF_PRE_LOW, 32'hf0);
      wr(`ACTIS_OFF_PRE_HIGH, 32'hff);
      wr(`ACTIS_OFF_TCTRL, 32'h10);
      rd(`ACTIS_OFF_TCTRL);
      chk(rd_d, 32'h0);
      wr(`ACTIS_OFF_AUTOCFG, 32'h140);
      pulse(1'b0);
      chk(timer_run_out, 1'b0);
      wr(`ACTIS_OFF_AUTOCFG, 32'h40);
      wr(`ACTIS_OFF_TCTRL, 32'h2); // Control set with auto off
      wr(`ACTIS_OFF_AUTOCFG, 32'h140);
      pulse(1'b1);
      chk(timer_run_out, 1'b0);
      pulse(1'b0);
      chk(timer_run_out, 1'b1);
      gap(1'b0);
      w3;
      chk(timer_run_out, 1'b0);
      chk(timer_count, 16'hfff0);
      wr(`ACTIS_OFF_AUTOCFG, 32'h0);
      wr(`ACTIS_OFF_PRE_LOW, 32'hff);
      wr(`ACTIS_OFF_PRE_HIGH, 32'hff);
      for (k = 0; k < 2; k = k + 1) begin // Both prescale settings
         wr(`ACTIS_OFF_TCTRL, k);
         wr(`ACTIS_OFF_AUTOCFG, 32'h80);
         wr(`ACTIS_OFF_AUTOCFG, 32'h180);
         w3;
         chk(timer_run_out, 1'b1);
         gap(1'b0);
         gap(1'b0);
         chk(t, 4 * DIV * (k + 1));
         wr(`ACTIS_OFF_AUTOCFG, 32'h80);
         w3;
         chk(timer_run_out, 1'b0);
      end
      wrap_up;
   end
   initial begin // Hang guard
      #(25 * 20000);
      fail_count = fail_count + 1;
      wrap_up;
   end
endmodule // adc_trigger_timer_input_select_test
